// ---- hw/omc_mode_ctrl.sv ----
// Operating-mode controller: run, debug, wait and stop sequencing
`timescale 1ns/1ps
//
// Contract
// - Mode pin high at reset release selects run mode.
// - Run mode starts execution at the fixed reset address.
// - No vector fetch; the reset address holds a jump with operand after it.
// - Mode pin low at power-on reset or after force-reset command gives debug mode.
// - Enter-debug command from host gives debug mode.
// - Halt-to-debug instruction gives debug mode.
// - Hardware breakpoint match gives debug mode.
// - In debug mode the CPU stays suspended, serving only debug commands.
// - Memory, memory-with-status and enter-debug commands work in run and debug.
// - Register access, trace and resume commands work only in debug mode.
// - Wait instruction stops the CPU clock and holds the program counter.
// - Mask set: pending flag ends wait, continue at next instruction.
// - Mask clear: pending flag saves next address, jumps to interrupt vector.
// - In wait only enter-debug, force-reset and status commands; status reports low-power error.
// - Enter-debug command during wait wakes into debug mode.
// - Wait keeps system clocks and clock generator running.
// - Stop halts system clocks, unless debug enable keeps them, while circuits stay powered.
// - Stop with stop enable clear forces an illegal-opcode reset.
module omc_mode_ctrl #(
   parameter int ADDR_W = omc_pkg::OMC_ADDR_W                      // Program counter width
) (
   input  wire logic                   clk_i,                      // Bus clock
   input  wire logic                   rst_i,                      // System reset, sync, high
   input  wire logic                   mode_pin_i,                 // Debug/mode-select pin level
   input  wire logic                   por_i,                      // Current reset is power-on
   input  wire logic                   exec_halt_i,                // Halt-to-debug instruction executed
   input  wire logic                   exec_wait_i,                // Wait instruction executed
   input  wire logic                   exec_stop_i,                // Stop instruction executed
   input  wire logic [ADDR_W-1:0]      exec_pc_i,                  // Address of executed instruction
   input  wire logic                   brk_match_i,                // Breakpoint match
   input  wire logic                   stop_enable_bit_i,          // Stop allowed
   input  wire logic                   interrupt_vector_mask_i,    // 1: no vectoring
   input  wire logic                   irq_pend_i,                 // Any pending flag set
   input  wire logic                   wake_async_i,               // Enabled async wake from stop
   input  wire logic                   debug_enable_i,             // Debug clocks kept alive in stop
   input  wire omc_pkg::omc_cmd_type   cmd_i,                      // Decoded debug command
   input  wire logic                   cmd_vld_i,                  // Command strobe
   input  wire logic                   trace_done_i,               // Traced instruction finished
   output logic                        cpu_run_o,                  // CPU clock enable
   output logic                        sys_clk_en_o,               // System clocks enabled
   output logic                        clkgen_en_o,                // Clock generator enabled
   output logic                        debug_active_o,             // In active debug mode
   output logic                        wait_o,                     // In wait mode
   output logic                        stop_o,                     // In stop mode
   output logic                        pc_load_o,                  // Load program counter (pulse)
   output logic [ADDR_W-1:0]           pc_val_o,                   // Program counter value to load
   output logic                        ira_load_o,                 // Load return address (pulse)
   output logic [ADDR_W-1:0]           interrupt_return_address_o, // Return address value
   output logic                        cmd_accept_o,               // Command carried out (pulse)
   output logic                        cmd_err_o,                  // Status error wait/stop (pulse)
   output logic                        illegal_rst_o,              // Illegal-opcode reset (pulse)
   output logic                        force_rst_o                 // Debug force reset (pulse)
);
   import omc_pkg::*;

   // ******************************************************************
   // Declarations
   // ******************************************************************
   omc_state_type     state_r;
   omc_state_type     state_nxt;
   logic              accept;
   logic              lowpwr;
   logic              fresh_dbg_r;
   logic [ADDR_W-1:0] held_pc_r;
   logic [ADDR_W-1:0] pc_nxt;
   logic              pc_load_nxt;
   logic              ira_load_nxt;
   logic              go_debug;

   function automatic logic [ADDR_W-1:0] next_addr(input logic [ADDR_W-1:0] a);
      next_addr = a + ADDR_W'(OMC_PC_STEP);
   endfunction : next_addr

   // ******************************************************************
   // Command gating
   // ******************************************************************
   omc_cmd_gate u_gate (
      .state_i   (state_r),
      .cmd_i     (cmd_i),
      .cmd_vld_i (cmd_vld_i),
      .accept_o  (accept),
      .lowpwr_o  (lowpwr)
   );

   // Debug entry from any running or low-power state
   assign go_debug = (accept && cmd_i == OMC_CMD_ENTER) ||
                     ((state_r == OMC_ST_RUN) && (exec_halt_i || brk_match_i));

   // ******************************************************************
   // Reset mode latch
   // ******************************************************************
   // Set on force-reset command only; pin sampled on the release edge.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fresh_dbg_r <= 1'b0;
      end else if (accept && cmd_i == OMC_CMD_FRESET) begin
         fresh_dbg_r <= 1'b1;
      end else if (state_r == OMC_ST_RESET) begin
         fresh_dbg_r <= 1'b0;
      end
   end

   // ******************************************************************
   // Next-state logic
   // ******************************************************************
   always_comb begin
      state_nxt    = state_r;
      pc_nxt       = held_pc_r;
      pc_load_nxt  = 1'b0;
      ira_load_nxt = 1'b0;
      case (state_r)
         OMC_ST_RESET: begin
            // Low pin only honoured for power-on or forced reset
            if (!mode_pin_i && (por_i || fresh_dbg_r)) begin
               state_nxt = OMC_ST_DEBUG;
            end else begin
               state_nxt = OMC_ST_RUN;
            end
            pc_nxt      = ADDR_W'(OMC_RESET_ADDR);
            pc_load_nxt = 1'b1;
         end
         OMC_ST_RUN: begin
            if (go_debug) begin
               state_nxt = OMC_ST_DEBUG;
               pc_nxt    = exec_pc_i;
            end else if (exec_wait_i) begin
               state_nxt = OMC_ST_WAIT;
               pc_nxt    = exec_pc_i;
            end else if (exec_stop_i && stop_enable_bit_i) begin
               state_nxt = OMC_ST_STOP;
               pc_nxt    = exec_pc_i;
            end
         end
         OMC_ST_WAIT, OMC_ST_STOP: begin
            if (go_debug) begin
               state_nxt = OMC_ST_DEBUG;
            end else if (irq_pend_i || (state_r == OMC_ST_STOP && wake_async_i)) begin
               state_nxt   = OMC_ST_RUN;
               pc_load_nxt = 1'b1;
               if (interrupt_vector_mask_i == OMC_INTERRUPT_VECTOR_MASK_NOVEC) begin
                  pc_nxt = next_addr(held_pc_r);
               end else begin
                  pc_nxt       = ADDR_W'(OMC_IRQ_VECTOR);
                  ira_load_nxt = 1'b1;
               end
            end
         end
         OMC_ST_DEBUG: begin
            if (accept && cmd_i == OMC_CMD_RESUME) begin
               state_nxt   = OMC_ST_RUN;
               pc_load_nxt = 1'b1;
            end else if (accept && cmd_i == OMC_CMD_TRACE) begin
               state_nxt = OMC_ST_TRACE;
            end
         end
         OMC_ST_TRACE: begin
            if (trace_done_i) begin
               state_nxt = OMC_ST_DEBUG;
               pc_nxt    = exec_pc_i;
            end
         end
         default: begin
            state_nxt = OMC_ST_RESET;
         end
      endcase
      // Forced reset overrides every mode except trace, so outputs never show a stale mode
      if (accept && cmd_i == OMC_CMD_FRESET) begin
         state_nxt    = OMC_ST_RESET;
         pc_load_nxt  = 1'b0;
         ira_load_nxt = 1'b0;
      end
   end

   // ******************************************************************
   // State and program counter registers
   // ******************************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r <= OMC_ST_RESET;
      end else if (accept && cmd_i == OMC_CMD_FRESET) begin
         state_r <= OMC_ST_RESET;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         held_pc_r <= '0;
      end else begin
         held_pc_r <= pc_nxt;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pc_load_o <= 1'b0;
         pc_val_o  <= '0;
      end else begin
         pc_load_o <= pc_load_nxt;
         pc_val_o  <= pc_nxt;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ira_load_o                 <= 1'b0;
         interrupt_return_address_o <= '0;
      end else begin
         ira_load_o <= ira_load_nxt;
         if (ira_load_nxt) begin
            interrupt_return_address_o <= next_addr(held_pc_r);
         end
      end
   end

   // ******************************************************************
   // Mode and clock outputs
   // ******************************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cpu_run_o      <= 1'b0;
         debug_active_o <= 1'b0;
         wait_o         <= 1'b0;
         stop_o         <= 1'b0;
      end else begin
         // CPU only clocked in run or single-step
         cpu_run_o      <= (state_nxt == OMC_ST_RUN) || (state_nxt == OMC_ST_TRACE);
         debug_active_o <= (state_nxt == OMC_ST_DEBUG) || (state_nxt == OMC_ST_TRACE);
         wait_o         <= (state_nxt == OMC_ST_WAIT);
         stop_o         <= (state_nxt == OMC_ST_STOP);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sys_clk_en_o <= 1'b1;
         clkgen_en_o  <= 1'b1;
      end else begin
         // Wait keeps everything running; stop halts them unless debug keeps them
         sys_clk_en_o <= (state_nxt != OMC_ST_STOP) || debug_enable_i;
         clkgen_en_o  <= (state_nxt != OMC_ST_STOP) || debug_enable_i;
      end
   end

   // ******************************************************************
   // Command answers and resets
   // ******************************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cmd_accept_o  <= 1'b0;
         cmd_err_o     <= 1'b0;
         force_rst_o   <= 1'b0;
         illegal_rst_o <= 1'b0;
      end else begin
         cmd_accept_o  <= accept;
         cmd_err_o     <= lowpwr;
         force_rst_o   <= accept && (cmd_i == OMC_CMD_FRESET);
         illegal_rst_o <= (state_r == OMC_ST_RUN) && !go_debug && !exec_wait_i &&
                          exec_stop_i && !stop_enable_bit_i;
      end
   end
endmodule : omc_mode_ctrl

// ---- hw/omc_pkg.sv ----
// Package: constants and types for the operating-mode controller
package omc_pkg;
   localparam int          OMC_ADDR_W        = 14;
   localparam logic [13:0] OMC_RESET_ADDR    = 14'h3FFD;
   localparam logic [13:0] OMC_JMP_OPND_HI   = 14'h3FFE;
   localparam logic [13:0] OMC_JMP_OPND_LO   = 14'h3FFF;
   localparam logic [13:0] OMC_IRQ_VECTOR    = 14'h3FF7;
   localparam logic [13:0] OMC_PC_STEP       = 14'h0001;
   localparam logic        OMC_INTERRUPT_VECTOR_MASK_NOVEC   = 1'b1;

   // Debug command classes as decoded by the serial front end
   typedef enum logic [2:0] {
      OMC_CMD_NONE     = 3'b000,
      OMC_CMD_MEM      = 3'b001,
      OMC_CMD_MEM_STAT = 3'b010,
      OMC_CMD_ENTER    = 3'b011,
      OMC_CMD_REG      = 3'b100,
      OMC_CMD_TRACE    = 3'b101,
      OMC_CMD_RESUME   = 3'b110,
      OMC_CMD_FRESET   = 3'b111
   } omc_cmd_type;

   typedef enum logic [2:0] {
      OMC_ST_RESET = 3'b000,
      OMC_ST_RUN   = 3'b001,
      OMC_ST_DEBUG = 3'b010,
      OMC_ST_WAIT  = 3'b011,
      OMC_ST_STOP  = 3'b100,
      OMC_ST_TRACE = 3'b101
   } omc_state_type;
endpackage : omc_pkg

// ---- hw/omc_cmd_gate.sv ----
// Command gate: decides which debug commands are accepted in each mode
`timescale 1ns/1ps
module omc_cmd_gate (
   input  wire omc_pkg::omc_state_type state_i,    // Current operating mode
   input  wire omc_pkg::omc_cmd_type   cmd_i,      // Command class
   input  wire logic                   cmd_vld_i,  // Command strobe
   output logic                        accept_o,   // Command carried out
   output logic                        lowpwr_o    // Status error: wait or stop
);
   import omc_pkg::*;

   always_comb begin
      accept_o = 1'b0;
      lowpwr_o = 1'b0;
      if (cmd_vld_i) begin
         case (state_i)
            OMC_ST_RUN: begin
               accept_o = (cmd_i == OMC_CMD_MEM) || (cmd_i == OMC_CMD_MEM_STAT) ||
                          (cmd_i == OMC_CMD_ENTER) || (cmd_i == OMC_CMD_FRESET);
            end
            OMC_ST_DEBUG: begin
               accept_o = (cmd_i != OMC_CMD_NONE);
            end
            OMC_ST_WAIT, OMC_ST_STOP: begin
               // Status commands answer with an error and touch no memory
               accept_o = (cmd_i == OMC_CMD_ENTER) || (cmd_i == OMC_CMD_FRESET);
               lowpwr_o = (cmd_i == OMC_CMD_MEM_STAT);
            end
            default: begin
               accept_o = 1'b0;
            end
         endcase
      end
   end
endmodule : omc_cmd_gate

// ---- test/omc_mode_ctrl_properties.sv ----
// Checker: port-level properties of the mode controller
`timescale 1ns/1ps
module omc_mode_ctrl_props
   import omc_pkg::*;
#(
   parameter int ADDR_W = 14  // PC width
) (
   input wire logic clk_i,                    // Clock
   input wire logic rst_i,                    // Reset
   input wire logic mode_pin_i,               // Mode pin
   input wire logic exec_halt_i,              // Halt
   input wire logic exec_stop_i,              // Stop
   input wire logic exec_wait_i,              // Wait
   input wire logic brk_match_i,              // Breakpoint
   input wire logic stop_enable_bit_i,        // Stop allowed
   input wire logic interrupt_vector_mask_i,  // No vectoring
   input wire logic irq_pend_i,               // Pending
   input wire logic debug_enable_i,           // Debug clocks
   input wire omc_pkg::omc_cmd_type cmd_i,    // Command
   input wire logic cmd_vld_i,                // Strobe
   input wire logic cpu_run_o,                // CPU on
   input wire logic sys_clk_en_o,             // Clocks
   input wire logic clkgen_en_o,              // Generator
   input wire logic debug_active_o,           // Debug
   input wire logic wait_o,                   // Wait
   input wire logic stop_o,                   // Stop
   input wire logic pc_load_o,                // PC load
   input wire logic [ADDR_W-1:0] pc_val_o,    // PC value
   input wire logic ira_load_o,               // Return load
   input wire logic cmd_accept_o,             // Accept
   input wire logic cmd_err_o,                // Error
   input wire logic illegal_rst_o             // Illegal reset
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_boot_mode: assert property ($fell(rst_i) && mode_pin_i |=> cpu_run_o && !debug_active_o)
      else $error("run mode not selected");
   a_boot_addr: assert property ($fell(rst_i) |=> pc_load_o && pc_val_o == OMC_RESET_ADDR)
      else $error("boot address wrong");
   a_enter_cmd_debug: assert property (cmd_vld_i && cmd_i == OMC_CMD_ENTER && (cpu_run_o || wait_o)
      |=> cmd_accept_o && debug_active_o)
      else $error("enter command ignored");
   a_halt_to_debug: assert property (cpu_run_o && (exec_halt_i || brk_match_i) |=> debug_active_o && !cpu_run_o)
      else $error("halt or breakpoint ignored");
   a_active_cmd_gated: assert property (cmd_vld_i && cmd_i inside {OMC_CMD_REG, OMC_CMD_TRACE, OMC_CMD_RESUME}
      && !debug_active_o |=> !cmd_accept_o)
      else $error("active command outside debug");
   a_wait_holds: assert property (wait_o && !irq_pend_i && !cmd_vld_i |=> wait_o && !cpu_run_o && !pc_load_o)
      else $error("wait left without cause");
   a_wake_novec: assert property (wait_o && irq_pend_i && interrupt_vector_mask_i && !cmd_vld_i
      |=> pc_load_o && !ira_load_o && !wait_o)
      else $error("wake without vector wrong");
   a_wake_vector: assert property (wait_o && irq_pend_i && !interrupt_vector_mask_i && !cmd_vld_i
      |=> ira_load_o && pc_val_o == OMC_IRQ_VECTOR)
      else $error("vectored wake wrong");
   a_wait_status_err: assert property ((wait_o || stop_o) && cmd_vld_i && cmd_i == OMC_CMD_MEM_STAT
      |=> cmd_err_o && !cmd_accept_o)
      else $error("status command in low power");
   a_wait_clocks: assert property (wait_o |-> sys_clk_en_o && clkgen_en_o)
      else $error("clocks stopped in wait");
   a_stop_clocks: assert property ($rose(stop_o) && !debug_enable_i |-> !sys_clk_en_o)
      else $error("clocks run in stop");
   a_stop_refused: assert property (cpu_run_o && exec_stop_i && !stop_enable_bit_i && !exec_halt_i && !exec_wait_i
      && !brk_match_i && !cmd_vld_i |=> illegal_rst_o && !stop_o)
      else $error("stop not refused");
   c_wake: cover property (wait_o && irq_pend_i);
   c_illegal: cover property (illegal_rst_o);
   c_resume: cover property (debug_active_o && cmd_vld_i && cmd_i == OMC_CMD_RESUME);
endmodule : omc_mode_ctrl_props

// ---- test/omc_dbg_host.sv ----
// Debug host model: mode pin and command strobe
`timescale 1ns/1ps
module omc_dbg_host
   import omc_pkg::*;
(
   input  wire logic  clk_i,      // Bus clock
   output logic       mode_pin_o, // Mode pin level
   output omc_cmd_type cmd_o,     // Command class
   output logic       cmd_vld_o   // Command strobe
);
   initial begin
      mode_pin_o = 1'b1; // Pull-up gives run mode when idle
      cmd_o = OMC_CMD_NONE;
      cmd_vld_o = 1'b0;
   end
   task automatic hold_pin(input logic lvl);
      mode_pin_o = lvl;
   endtask : hold_pin
   // One-cycle strobe; class bus shows junk once released
   task automatic send(input omc_cmd_type c);
      @(negedge clk_i);
      cmd_o = c;
      cmd_vld_o = 1'b1;
      @(negedge clk_i);
      cmd_vld_o = 1'b0;
      cmd_o = omc_cmd_type'(~c);
   endtask : send
endmodule : omc_dbg_host

// ---- test/omc_mode_ctrl_tb.sv ----
// Testbench: mode controller against a small reference model
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin failures++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module omc_mode_ctrl_tb;
   import omc_pkg::*;
   logic clk_i = 1'b0, rst_i = 1'b1, por_i = 1'b1, exec_halt_i = 1'b0, exec_wait_i = 1'b0, exec_stop_i = 1'b0;
   logic brk_match_i = 1'b0, stop_enable_bit_i = 1'b0, irq_pend_i = 1'b0, interrupt_vector_mask_i = 1'b1;
   logic wake_async_i = 1'b0, debug_enable_i = 1'b0, trace_done_i = 1'b0;
   logic mode_pin_i, cmd_vld_i, cpu_run_o, sys_clk_en_o, clkgen_en_o, debug_active_o, wait_o, stop_o;
   logic pc_load_o, ira_load_o, cmd_accept_o, cmd_err_o, illegal_rst_o, force_rst_o;
   logic [13:0] exec_pc_i = 14'h0000, pc_val_o, interrupt_return_address_o, a;
   omc_cmd_type cmd_i;
   int failures = 0, checked = 0, seed = 32'h0FDFBF36, md = 0;
   logic [13:0] held_q[$];
   omc_cmd_type seq[9] = '{OMC_CMD_REG, OMC_CMD_TRACE, OMC_CMD_RESUME, OMC_CMD_MEM, OMC_CMD_MEM_STAT,
                           OMC_CMD_ENTER, OMC_CMD_MEM, OMC_CMD_MEM_STAT, OMC_CMD_REG};
   always #10 clk_i = ~clk_i;
   omc_dbg_host host (.clk_i(clk_i), .mode_pin_o(mode_pin_i), .cmd_o(cmd_i), .cmd_vld_o(cmd_vld_i));
   omc_mode_ctrl uut (.*);
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_i);
   endtask : cyc
   task automatic finish_test;
      $display("Comparisons %0d, mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : finish_test
   task automatic do_reset(input logic pin, input logic por);
      rst_i = 1'b1;
      por_i = por;
      host.hold_pin(pin);
      cyc(3);
      rst_i = 1'b0;
      cyc(2);
      md = (pin || !por) ? 0 : 1;
      `CHK(pc_val_o, OMC_RESET_ADDR)
      `CHK(cpu_run_o, md == 0)
      host.hold_pin(1'b1);
   endtask : do_reset
   // Model of the command gate: 0 run, 1 debug, 2 wait, 3 stop
   task automatic cmd(input omc_cmd_type c);
      logic acc;
      acc = (md == 1) ? c != OMC_CMD_NONE : (md == 0) ? c inside {OMC_CMD_MEM, OMC_CMD_MEM_STAT, OMC_CMD_ENTER}
            : c == OMC_CMD_ENTER;
      host.send(c);
      `CHK(cmd_accept_o, acc)
      `CHK(cmd_err_o, md >= 2 && c == OMC_CMD_MEM_STAT)
      if (acc && c == OMC_CMD_ENTER) md = 1;
      if (acc && c == OMC_CMD_RESUME) begin
         md = 0;
         if (held_q.size() > 0) `CHK(pc_val_o, held_q.pop_front())
      end
      if (c != OMC_CMD_TRACE) begin
         `CHK(debug_active_o, md == 1)
         `CHK(cpu_run_o, md == 0)
      end
   endtask : cmd
   // Event index: 0 halt, 1 wait, 2 stop, 3 breakpoint
   task automatic ev(input int k);
      a = 14'($random(seed));
      exec_pc_i = a;
      {brk_match_i, exec_stop_i, exec_wait_i, exec_halt_i} = 4'h1 << k;
      cyc(1);
      {brk_match_i, exec_stop_i, exec_wait_i, exec_halt_i} = 4'h0;
      exec_pc_i = ~a;
   endtask : ev
   task automatic wake(input logic m);
      interrupt_vector_mask_i = m;
      irq_pend_i = 1'b1;
      cyc(1);
      irq_pend_i = 1'b0;
      `CHK(pc_val_o, m ? a + 14'h0001 : OMC_IRQ_VECTOR)
      `CHK(ira_load_o, !m)
      if (!m) `CHK(interrupt_return_address_o, a + 14'h0001)
      `CHK(cpu_run_o, 1'b1)
      md = 0;
   endtask : wake
   initial begin
      do_reset(1'b1, 1'b1);
      foreach (seq[i]) cmd(seq[i]);
      cmd(OMC_CMD_TRACE);
      trace_done_i = 1'b1;
      cyc(1);
      trace_done_i = 1'b0;
      cyc(1);
      `CHK(debug_active_o, 1'b1)
      cmd(OMC_CMD_RESUME);
      for (int k = 0; k < 4; k += 3) begin
         ev(k);
         held_q.push_back(a);
         md = 1;
         `CHK(debug_active_o, 1'b1)
         cmd(OMC_CMD_RESUME);
      end
      for (int m = 0; m < 3; m++) begin
         ev(1);
         md = 2;
         cyc(3);
         `CHK({wait_o, cpu_run_o, sys_clk_en_o, clkgen_en_o}, 4'hB)
         cmd(OMC_CMD_MEM_STAT);
         cmd(OMC_CMD_REG);
         if (m < 2) wake(m[0]);
      end
      cmd(OMC_CMD_ENTER);
      cmd(OMC_CMD_RESUME);
      ev(2);
      `CHK({illegal_rst_o, stop_o, cpu_run_o}, 3'h5)
      stop_enable_bit_i = 1'b1;
      ev(2);
      md = 3;
      `CHK({stop_o, sys_clk_en_o}, 2'h2)
      cmd(OMC_CMD_MEM_STAT);
      wake(1'b1);
      por_i = 1'b0;
      host.hold_pin(1'b0);
      host.send(OMC_CMD_FRESET);
      `CHK({force_rst_o, cpu_run_o}, 2'h2)
      cyc(1);
      `CHK({pc_load_o, debug_active_o}, 2'h3)
      host.hold_pin(1'b1);
      do_reset(1'b0, 1'b1);
      do_reset(1'b0, 1'b0);
      finish_test();
   end
endmodule : omc_mode_ctrl_tb
bind omc_mode_ctrl omc_mode_ctrl_props #(.ADDR_W(ADDR_W)) chk (.*);
